// >>> inc/mpfp_defs.vh
// Constants for the motor PWM fault protection block
`ifndef MPFP_DEFS_VH
`define MPFP_DEFS_VH

// Register byte offsets
`define MPFP_OFS_STOP_CTRL    5'h00
`define MPFP_OFS_STOP_STAT    5'h04
`define MPFP_OFS_DIS_KEY      5'h08
`define MPFP_OFS_OV_CTRL      5'h0C
`define MPFP_OFS_OV_STAT      5'h10

// Stop control fields
`define MPFP_SC_EN_BIT        0
`define MPFP_SC_REL_BIT       1
`define MPFP_SC_MODE_LO       3
`define MPFP_SC_TOOL_BIT      5
`define MPFP_SC_CNT_LO        8

// Over-voltage control fields
`define MPFP_OC_EN_BIT        0
`define MPFP_OC_AUTO_BIT      1
`define MPFP_OC_SEL_BIT       2
`define MPFP_OC_MODE_LO       3
`define MPFP_OC_ADC0_BIT      5
`define MPFP_OC_ADC1_BIT      6
`define MPFP_OC_CNT_LO        8

// Reset values
`define MPFP_RST_STOP_EN      1'b1
`define MPFP_RST_TOOL_EN      1'b1
`define MPFP_RST_STOP_MODE    2'b11
`define MPFP_RST_STOP_CNT     4'h0
`define MPFP_RST_OV_MODE      2'b00
`define MPFP_RST_OV_CNT       4'h0

// Disable key codes
`define MPFP_KEY_FIRST        8'h5A
`define MPFP_KEY_SECOND       8'hA5

// Filter step: one count of a detection field is two to this power clocks
`define MPFP_FILT_SHIFT       4

// Output pattern codes
`define MPFP_MD_UPPER         2'b01
`define MPFP_MD_LOWER         2'b10
`define MPFP_MD_NONE          2'b00

`endif

// >>> rtl/mpfp_top.v
// Motor PWM fault protection: emergency stop and over-voltage output override
//
// Function
// (RULE_01) Emergency input filtered for field times sixteen clocks; zero bypasses filter.
// (RULE_02) Tool break enable, set at reset, lets debug stop disable the outputs.
// (RULE_03) Emergency mode: 00/11 all high-Z, 01 upper PWM lower high-Z, 10 reverse.
// (RULE_04) Release write works only when second-stage conduction buffer is all zero.
// (RULE_05) Release bit acts on write of one, zero ignored, always reads zero.
// (RULE_06) Software checks input level reads one before writing release.
// (RULE_07) Emergency enable clears only right after key writes 5A then A5.
// (RULE_08) Emergency protection enable resets to one.
// (RULE_09) Stop status: bit 1 input level, bit 0 protection state.
// (RULE_10) Over-voltage held low for filter time forces fixed outputs, raises interrupt.
// (RULE_11) Over-voltage status bit reads one while protection is in force.
// (RULE_12) Over-voltage release only with input high, at counter equal period or one.
// (RULE_13) Auto-release bit set releases at next period update; clear never releases.
// (RULE_14) Over-voltage enable clears only right after key writes 5A then A5.
// (RULE_15) Over-voltage filter field times sixteen clocks, zero as one, port only.
// (RULE_16) Two enables gate ADC monitor results 1 and 0 as over-voltage sources.
// (RULE_17) Over-voltage mode: 00 none, 01 upper active, 10 lower active, 11 all off.
// (RULE_18) Emergency pattern takes precedence over over-voltage pattern.
// (RULE_19) Source select: zero filtered port input, one unfiltered ADC monitor signal.
// (RULE_20) Emergency assertion disables outputs at once by mode and raises interrupt.
// (RULE_21) Release attempts while emergency input is low are ignored.
// (RULE_22) Each interrupt is one clock pulse on entry to its protection state.
`timescale 1ns/1ps
`default_nettype none
`include "mpfp_defs.vh"

module mpfp_top #(
   parameter CNT_W = 16
) (
   input  wire             CLK,
   input  wire             ARST_N,
   input  wire             CE,
   input  wire [4:0]       AVS_ADDRESS,
   input  wire             AVS_READ,
   input  wire             AVS_WRITE,
   input  wire [31:0]      AVS_WRITEDATA,
   input  wire [3:0]       AVS_BYTEENABLE,
   output reg  [31:0]      AVS_READDATA,
   output wire             AVS_WAITREQUEST,
   input  wire             EMERGENCY_STOP_N,
   input  wire             TOOL_STOP,
   input  wire             OV_INPUT_N,
   input  wire             ADC_MONITOR0,
   input  wire             ADC_MONITOR1,
   input  wire [CNT_W-1:0] PWM_COUNTER,
   input  wire [CNT_W-1:0] PWM_PERIOD,
   input  wire             HALF_CYCLE_INT,
   input  wire             CONDUCTION_ZERO,
   input  wire             POL_HIGH,
   input  wire             POL_LOW,
   input  wire [5:0]       PWM_IN,
   output reg  [5:0]       PHASE_OUT,
   output reg  [5:0]       PHASE_OE,
   output reg              STOP_INTERRUPT,
   output reg              OV_INTERRUPT,
   output reg              STOP_PROTECT_STATE,
   output reg              OV_PROTECT_STATE
);

   localparam KEY_IDLE  = 2'd0;
   localparam KEY_FIRST = 2'd1;
   localparam KEY_ARMED = 2'd2;

   // Control registers
   reg        stop_en_q;
   reg        tool_en_q;
   reg [1:0]  stop_mode_q;
   reg [3:0]  stop_cnt_q;
   reg        ov_en_q;
   reg        ov_auto_q;
   reg        ov_sel_q;
   reg [1:0]  ov_mode_q;
   reg        adc0_en_q;
   reg        adc1_en_q;
   reg [3:0]  ov_cnt_q;
   reg [1:0]  key_q;
   reg        ack_q;

   // Filters and input levels
   reg [8:0]  stop_filt_q;
   reg [8:0]  ov_filt_q;
   reg        stop_lvl_q;
   reg        ov_lvl_q;

   wire       acc     = AVS_READ | AVS_WRITE;
   wire       wr_stb  = AVS_WRITE & ~ack_q & CE;
   wire       wr_sc   = wr_stb & (AVS_ADDRESS == `MPFP_OFS_STOP_CTRL);
   wire       wr_key  = wr_stb & (AVS_ADDRESS == `MPFP_OFS_DIS_KEY) & AVS_BYTEENABLE[0];
   wire       wr_oc   = wr_stb & (AVS_ADDRESS == `MPFP_OFS_OV_CTRL);
   wire       armed   = (key_q == KEY_ARMED);

   // One wait state on every access; the answer comes on the second edge
   assign AVS_WAITREQUEST = acc & ~ack_q;

   // Filter thresholds in clocks
   wire [8:0] stop_thr = {1'b0, stop_cnt_q, 4'h0};
   wire [3:0] ov_cnt_e = (ov_cnt_q == 4'h0) ? 4'h1 : ov_cnt_q;
   wire [8:0] ov_thr   = {1'b0, ov_cnt_e, 4'h0};

   wire       stop_asrt = ~EMERGENCY_STOP_N;
   wire       port_asrt = ~OV_INPUT_N;
   wire [8:0] stop_nxt  = (stop_filt_q == 9'h1FF) ? stop_filt_q : stop_filt_q + 9'h001;
   wire [8:0] ov_nxt    = (ov_filt_q == 9'h1FF) ? ov_filt_q : ov_filt_q + 9'h001;

   // Zero stop field detects on the first low sample; zero over-voltage field counts as one
   wire stop_det = stop_asrt & ((stop_cnt_q == 4'h0) | (stop_nxt >= stop_thr)); // see RULE_01
   wire port_det = port_asrt & (ov_nxt >= ov_thr);                            // see RULE_15
   wire adc_det  = (ADC_MONITOR1 & adc1_en_q) | (ADC_MONITOR0 & adc0_en_q);   // see RULE_16
   wire ov_det   = ov_sel_q ? adc_det : port_det;                             // see RULE_19
   wire ov_asrt  = ov_sel_q ? adc_det : port_asrt;

   wire stop_set = stop_en_q & stop_det & ~STOP_PROTECT_STATE;                // see RULE_20
   wire ov_set   = ov_en_q & ov_det & ~OV_PROTECT_STATE;                      // see RULE_10

   // Release needs a quiet input and an empty conduction buffer
   wire rel_req  = wr_sc & AVS_BYTEENABLE[0] & AVS_WRITEDATA[`MPFP_SC_REL_BIT]; // see RULE_05
   wire stop_rel = rel_req & CONDUCTION_ZERO & ~stop_asrt;             // see RULE_04, see RULE_21

   wire rel_pt   = (PWM_COUNTER == PWM_PERIOD) |
                   (HALF_CYCLE_INT & (PWM_COUNTER == {{(CNT_W-1){1'b0}}, 1'b1})); // see RULE_12
   wire ov_rel   = ov_auto_q & ~ov_asrt & rel_pt;                       // see RULE_13

   // Disabling takes the key sequence; any other write spoils it
   wire stop_en_wd = AVS_WRITEDATA[`MPFP_SC_EN_BIT] | ~armed;           // see RULE_07
   wire ov_en_wd   = AVS_WRITEDATA[`MPFP_OC_EN_BIT] | ~armed;           // see RULE_14

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_q <= 1'b0;
      end else if (CE) begin
         ack_q <= acc & ~ack_q;
      end
   end

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         stop_en_q   <= `MPFP_RST_STOP_EN;                               // see RULE_08
         tool_en_q   <= `MPFP_RST_TOOL_EN;                               // see RULE_02
         stop_mode_q <= `MPFP_RST_STOP_MODE;
         stop_cnt_q  <= `MPFP_RST_STOP_CNT;
         ov_en_q     <= 1'b0;
         ov_auto_q   <= 1'b0;
         ov_sel_q    <= 1'b0;
         ov_mode_q   <= `MPFP_RST_OV_MODE;
         adc0_en_q   <= 1'b0;
         adc1_en_q   <= 1'b0;
         ov_cnt_q    <= `MPFP_RST_OV_CNT;
         key_q       <= KEY_IDLE;
      end else if (CE) begin
         if (wr_sc && AVS_BYTEENABLE[0]) begin
            stop_en_q   <= stop_en_wd;
            stop_mode_q <= AVS_WRITEDATA[`MPFP_SC_MODE_LO+1:`MPFP_SC_MODE_LO];
            tool_en_q   <= AVS_WRITEDATA[`MPFP_SC_TOOL_BIT];
         end
         if (wr_sc && AVS_BYTEENABLE[1]) begin
            stop_cnt_q <= AVS_WRITEDATA[`MPFP_SC_CNT_LO+3:`MPFP_SC_CNT_LO];
         end
         if (wr_oc && AVS_BYTEENABLE[0]) begin
            ov_en_q   <= ov_en_wd;
            ov_auto_q <= AVS_WRITEDATA[`MPFP_OC_AUTO_BIT];
            ov_sel_q  <= AVS_WRITEDATA[`MPFP_OC_SEL_BIT];
            ov_mode_q <= AVS_WRITEDATA[`MPFP_OC_MODE_LO+1:`MPFP_OC_MODE_LO];
            adc0_en_q <= AVS_WRITEDATA[`MPFP_OC_ADC0_BIT];
            adc1_en_q <= AVS_WRITEDATA[`MPFP_OC_ADC1_BIT];
         end
         if (wr_oc && AVS_BYTEENABLE[1]) begin
            ov_cnt_q <= AVS_WRITEDATA[`MPFP_OC_CNT_LO+3:`MPFP_OC_CNT_LO];
         end
         // Key tracks consecutive writes only
         if (wr_key && AVS_WRITEDATA[7:0] == `MPFP_KEY_FIRST) begin
            key_q <= KEY_FIRST;
         end else if (wr_key && key_q == KEY_FIRST &&
                      AVS_WRITEDATA[7:0] == `MPFP_KEY_SECOND) begin
            key_q <= KEY_ARMED;
         end else if (wr_stb) begin
            key_q <= KEY_IDLE;                                  // see RULE_07, see RULE_14
         end
      end
   end

   // Input filters and level samples
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         stop_filt_q <= 9'h000;
         ov_filt_q   <= 9'h000;
         stop_lvl_q  <= 1'b1;
         ov_lvl_q    <= 1'b1;
      end else if (CE) begin
         stop_filt_q <= stop_asrt ? stop_nxt : 9'h000;                    // see RULE_01
         ov_filt_q   <= port_asrt ? ov_nxt : 9'h000;                      // see RULE_15
         stop_lvl_q  <= EMERGENCY_STOP_N;
         ov_lvl_q    <= ~ov_asrt;
      end
   end

   // Protection states; a new event wins over a release in the same cycle
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         STOP_PROTECT_STATE <= 1'b0;
         OV_PROTECT_STATE   <= 1'b0;
         STOP_INTERRUPT     <= 1'b0;
         OV_INTERRUPT       <= 1'b0;
      end else if (CE) begin
         if (stop_set) begin
            STOP_PROTECT_STATE <= 1'b1;
         end else if (stop_rel || !stop_en_q) begin
            STOP_PROTECT_STATE <= 1'b0;
         end
         if (ov_set) begin
            OV_PROTECT_STATE <= 1'b1;
         end else if (ov_rel || !ov_en_q) begin
            OV_PROTECT_STATE <= 1'b0;                                   // see RULE_11
         end
         STOP_INTERRUPT <= stop_set;                          // see RULE_22, see RULE_20
         OV_INTERRUPT   <= ov_set;                            // see RULE_22, see RULE_10
      end
   end

   // Output override; PWM_IN[2:0] are upper phases, [5:3] lower
   reg [5:0] out_d;
   reg [5:0] oe_d;
   always @* begin
      out_d = PWM_IN;
      oe_d  = 6'h3F;
      if (OV_PROTECT_STATE) begin                                         // see RULE_17
         case (ov_mode_q)
            `MPFP_MD_NONE: begin
               out_d = PWM_IN;
            end
            `MPFP_MD_UPPER: begin
               out_d = {{3{~POL_LOW}}, {3{POL_HIGH}}};
            end
            `MPFP_MD_LOWER: begin
               out_d = {{3{POL_LOW}}, {3{~POL_HIGH}}};
            end
            default: begin
               out_d = {{3{~POL_LOW}}, {3{~POL_HIGH}}};
            end
         endcase
      end
      // Emergency pattern overrides whatever over-voltage chose
      if (STOP_PROTECT_STATE) begin                             // see RULE_18, see RULE_03
         out_d = PWM_IN;
         case (stop_mode_q)
            `MPFP_MD_UPPER: begin
               oe_d = 6'h07;
            end
            `MPFP_MD_LOWER: begin
               oe_d = 6'h38;
            end
            default: begin
               oe_d = 6'h00;
            end
         endcase
      end
      if (tool_en_q && TOOL_STOP) begin                                   // see RULE_02
         oe_d = 6'h00;
      end
   end

   // Registered outputs add one cycle of latency to every override
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PHASE_OUT <= 6'h00;
         PHASE_OE  <= 6'h00;
      end else if (CE) begin
         PHASE_OUT <= out_d;
         PHASE_OE  <= oe_d;
      end
   end

   // Read mux; key register and release bit read zero
   reg [31:0] rd_d;
   always @* begin
      rd_d = 32'h0000_0000;
      case (AVS_ADDRESS)
         `MPFP_OFS_STOP_CTRL: begin
            rd_d[`MPFP_SC_EN_BIT]                       = stop_en_q;
            rd_d[`MPFP_SC_MODE_LO+1:`MPFP_SC_MODE_LO]   = stop_mode_q;
            rd_d[`MPFP_SC_TOOL_BIT]                     = tool_en_q;
            rd_d[`MPFP_SC_CNT_LO+3:`MPFP_SC_CNT_LO]     = stop_cnt_q;    // see RULE_05
         end
         `MPFP_OFS_STOP_STAT: begin
            rd_d[1:0] = {stop_lvl_q, STOP_PROTECT_STATE};                 // see RULE_09
         end
         `MPFP_OFS_OV_CTRL: begin
            rd_d[`MPFP_OC_EN_BIT]                       = ov_en_q;
            rd_d[`MPFP_OC_AUTO_BIT]                     = ov_auto_q;
            rd_d[`MPFP_OC_SEL_BIT]                      = ov_sel_q;
            rd_d[`MPFP_OC_MODE_LO+1:`MPFP_OC_MODE_LO]   = ov_mode_q;
            rd_d[`MPFP_OC_ADC0_BIT]                     = adc0_en_q;
            rd_d[`MPFP_OC_ADC1_BIT]                     = adc1_en_q;
            rd_d[`MPFP_OC_CNT_LO+3:`MPFP_OC_CNT_LO]     = ov_cnt_q;
         end
         `MPFP_OFS_OV_STAT: begin
            rd_d[1:0] = {ov_lvl_q, OV_PROTECT_STATE};                     // see RULE_11
         end
         default: begin
            rd_d = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (CE && AVS_READ && !ack_q) begin
         AVS_READDATA <= rd_d;
      end
   end

endmodule // mpfp_top
`default_nettype wire

// >>> verification/mpfp_asserts.sv
// Port-level assertion checker for the motor PWM fault protection block
`timescale 1ns/1ps
`default_nettype none
module mpfp_asserts #(
   parameter CNT_W = 16
) (
   input wire logic             CLK,
   input wire logic             ARST_N,
   input wire logic [4:0]       AVS_ADDRESS,
   input wire logic             AVS_READ,
   input wire logic             AVS_WRITE,
   input wire logic [31:0]      AVS_WRITEDATA,
   input wire logic             AVS_WAITREQUEST,
   input wire logic             EMERGENCY_STOP_N,
   input wire logic             TOOL_STOP,
   input wire logic [CNT_W-1:0] PWM_COUNTER,
   input wire logic [CNT_W-1:0] PWM_PERIOD,
   input wire logic             HALF_CYCLE_INT,
   input wire logic             CONDUCTION_ZERO,
   input wire logic [5:0]       PHASE_OE,
   input wire logic             STOP_INTERRUPT,
   input wire logic             OV_INTERRUPT,
   input wire logic             STOP_PROTECT_STATE,
   input wire logic             OV_PROTECT_STATE
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);

   sequence s_req_wait;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   // Release that keeps enable set; clearing enable drops the state by another path
   sequence s_release_wr;
      AVS_WRITE && AVS_ADDRESS == 5'h00 && AVS_WRITEDATA[1] && AVS_WRITEDATA[0];
   endsequence

   AST_BUS_ONE_WAIT: assert property (s_req_wait |=> !AVS_WAITREQUEST)
      else $error("bus answer not after one wait state");
   AST_STOP_IRQ_ENTRY: assert property (
      STOP_INTERRUPT == $rose(STOP_PROTECT_STATE))
      else $error("stop interrupt not a pulse at entry");
   AST_OV_IRQ_ENTRY: assert property (
      OV_INTERRUPT == $rose(OV_PROTECT_STATE))
      else $error("ov interrupt not a pulse at entry");
   AST_STOP_ENTRY_LOW: assert property (
      $rose(STOP_PROTECT_STATE) |-> !$past(EMERGENCY_STOP_N))
      else $error("stop state entered with input high");
   AST_STOP_PATTERN: assert property (
      STOP_PROTECT_STATE [*2] |-> PHASE_OE inside {6'h00, 6'h07, 6'h38})
      else $error("stop output pattern illegal");
   AST_RUN_DRIVE: assert property (
      (!STOP_PROTECT_STATE && !TOOL_STOP) [*2] |-> PHASE_OE == 6'h3F)
      else $error("phases not driven outside stop");
   AST_STOP_RELEASE: assert property (
      s_release_wr ##1 $fell(STOP_PROTECT_STATE) |-> $past(EMERGENCY_STOP_N && CONDUCTION_ZERO))
      else $error("stop state released illegally");
   AST_OV_RELEASE_POINT: assert property (
      !(AVS_WRITE && AVS_ADDRESS == 5'h0C) ##1 $fell(OV_PROTECT_STATE)
      |-> $past(PWM_COUNTER == PWM_PERIOD || (HALF_CYCLE_INT && PWM_COUNTER == 1)))
      else $error("ov state released off the period point");
endmodule // mpfp_asserts

bind mpfp_top mpfp_asserts #(.CNT_W(CNT_W)) u_asserts (
   .CLK, .ARST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_WAITREQUEST,
   .EMERGENCY_STOP_N, .TOOL_STOP, .PWM_COUNTER, .PWM_PERIOD, .HALF_CYCLE_INT,
   .CONDUCTION_ZERO, .PHASE_OE, .STOP_INTERRUPT, .OV_INTERRUPT, .STOP_PROTECT_STATE,
   .OV_PROTECT_STATE
);
`default_nettype wire

// >>> verification/mpfp_bench.sv
// Self-checking bench for the motor PWM fault protection block
`timescale 1ns/1ps
`default_nettype none
module mpfp_bench;
   logic        clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, tool = 1'b0, half = 1'b0;
   logic        stop_n = 1'b1, ov_n = 1'b1, adc0 = 1'b0, adc1 = 1'b0, polh = 1'b1;
   logic        poll = 1'b1, czero = 1'b0, w, sirq, oirq, sst, ost;
   logic [4:0]  addr = 5'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat, d;
   logic [15:0] cnt, prd;
   logic [5:0]  pin, out, oe, pin_q;
   logic [3:0]  f;
   int          fail_count = 0, n_tests = 0, cyc = 0, k;

   mpfp_top DUT (.CLK(clk), .ARST_N(arst_n), .CE(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'h3), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(w), .EMERGENCY_STOP_N(stop_n), .TOOL_STOP(tool), .OV_INPUT_N(ov_n),
      .ADC_MONITOR0(adc0), .ADC_MONITOR1(adc1), .PWM_COUNTER(cnt), .PWM_PERIOD(prd),
      .HALF_CYCLE_INT(half), .CONDUCTION_ZERO(czero), .POL_HIGH(polh), .POL_LOW(poll),
      .PWM_IN(pin), .PHASE_OUT(out), .PHASE_OE(oe), .STOP_INTERRUPT(sirq),
      .OV_INTERRUPT(oirq), .STOP_PROTECT_STATE(sst), .OV_PROTECT_STATE(ost));
   mpfp_gate_model u_gate (.clk(clk), .arst_n(arst_n), .cnt(cnt), .prd(prd), .pwm_in(pin));

   always #4 clk = ~clk;

   // Phase drive as the design captured it at the last edge
   always @(posedge clk) pin_q <= pin;

   function logic [31:0] sc(input logic [3:0] fc, input logic [1:0] m, input logic rel, en);
      return {20'h0_0000, fc, 3'h1, m, 1'b0, rel, en};
   endfunction
   function logic [31:0] oc(input logic [3:0] fc, input logic [1:0] m, input logic s, a, en);
      return {20'h0_0000, fc, 2'h0, s, m, s, a, en};
   endfunction
   function logic [5:0] ovpat(input logic [1:0] m);
      return {{3{(m == 2'b10) ? poll : ~poll}}, {3{(m == 2'b01) ? polh : ~polh}}};
   endfunction

   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Held until waitrequest is seen low at a rising edge; values read right
   // after the edge are those that stood at it, since the design updates late
   task bus(input logic r, input logic [4:0] a, input logic [31:0] v);
      addr <= a;
      wdat <= v;
      rd <= r;
      wr <= !r;
      do begin
         @(posedge clk);
      end while (w !== 1'b0);
      d = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task rdchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b1, a, 32'h0000_0000);
      chk(d, e);
   endtask
   task wait_for(input logic ov);
      k = 0;
      do begin
         @(posedge clk);
         k++;
         @(negedge clk);
      end while ((ov ? ost : sst) !== 1'b1 && k < 400);
      chk(ov ? oirq : sirq, 1'b1);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict;
      end
   end

   initial begin
      k = $urandom(32'h0000_7fd9);
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rdchk(5'h00, 32'h0000_0039);
      rdchk(5'h04, 32'h0000_0002);
      rdchk(5'h14, 32'h0000_0000);
      $display("test reset values done");
      for (int m = 0; m < 4; m++) begin
         f = (m == 0) ? 4'h0 : (m == 3) ? 4'hF : 4'($urandom % 16);
         bus(1'b0, 5'h00, sc(f, m[1:0], 1'b0, 1'b1));
         stop_n <= 1'b0;
         wait_for(1'b0);
         chk(k, (f == 0) ? 1 : f * 16);
         @(negedge clk);
         chk({oe, out}, {(m == 1) ? 6'h07 : (m == 2) ? 6'h38 : 6'h00, pin_q});
         @(posedge clk);
         czero <= 1'b1;
         bus(1'b0, 5'h00, sc(f, m[1:0], 1'b1, 1'b1));
         rdchk(5'h04, 32'h0000_0001);
         stop_n <= 1'b1;
         czero <= 1'b0;
         @(posedge clk);
         rdchk(5'h04, 32'h0000_0003);
         bus(1'b0, 5'h00, sc(f, m[1:0], 1'b1, 1'b1));
         rdchk(5'h04, 32'h0000_0003);
         czero <= 1'b1;
         bus(1'b0, 5'h00, sc(f, m[1:0], 1'b1, 1'b1));
         rdchk(5'h04, 32'h0000_0002);
         rdchk(5'h00, sc(f, m[1:0], 1'b0, 1'b1));
      end
      $display("test stop modes done");
      bus(1'b0, 5'h00, sc(4'h0, 2'b11, 1'b0, 1'b0));
      rdchk(5'h00, sc(4'h0, 2'b11, 1'b0, 1'b1));
      // A foreign write between the key codes spoils the sequence
      bus(1'b0, 5'h08, 32'h0000_005A);
      bus(1'b0, 5'h0C, 32'h0000_0000);
      bus(1'b0, 5'h08, 32'h0000_00A5);
      bus(1'b0, 5'h00, sc(4'h0, 2'b11, 1'b0, 1'b0));
      rdchk(5'h00, sc(4'h0, 2'b11, 1'b0, 1'b1));
      bus(1'b0, 5'h08, 32'h0000_005A);
      bus(1'b0, 5'h08, 32'h0000_00A5);
      bus(1'b0, 5'h00, sc(4'h0, 2'b11, 1'b0, 1'b0));
      stop_n <= 1'b0;
      rdchk(5'h00, sc(4'h0, 2'b11, 1'b0, 1'b0));
      rdchk(5'h04, 32'h0000_0000);
      stop_n <= 1'b1;
      tool <= 1'b1;
      bus(1'b0, 5'h00, sc(4'h0, 2'b11, 1'b0, 1'b1));
      @(negedge clk);
      chk({sst, oe}, 7'h00);
      @(posedge clk);
      tool <= 1'b0;
      $display("test key and tool break done");
      for (int m = 0; m < 4; m++) begin
         f = (m == 1) ? 4'h0 : 4'($urandom % 4);
         polh <= 1'($urandom);
         poll <= 1'($urandom);
         half <= 1'($urandom);
         bus(1'b0, 5'h0C, oc(f, m[1:0], 1'b0, 1'b1, 1'b1));
         ov_n <= 1'b0;
         wait_for(1'b1);
         chk(k, ((f == 0) ? 1 : f) * 16);
         @(negedge clk);
         chk({oe, out}, {6'h3F, (m == 0) ? pin_q : ovpat(m[1:0])});
         @(posedge clk);
         rdchk(5'h10, 32'h0000_0001);
         ov_n <= 1'b1;
         k = 0;
         do begin
            @(negedge clk);
            k++;
         end while (ost !== 1'b0 && k < 100);
         chk(k < 100, 1'b1);
         @(posedge clk);
      end
      bus(1'b0, 5'h0C, oc(4'h0, 2'b11, 1'b0, 1'b0, 1'b1));
      ov_n <= 1'b0;
      wait_for(1'b1);
      @(posedge clk);
      ov_n <= 1'b1;
      repeat (100) @(posedge clk);
      rdchk(5'h10, 32'h0000_0003);
      bus(1'b0, 5'h08, 32'h0000_005A);
      bus(1'b0, 5'h08, 32'h0000_00A5);
      bus(1'b0, 5'h0C, oc(4'h0, 2'b11, 1'b0, 1'b0, 1'b0));
      rdchk(5'h10, 32'h0000_0002);
      bus(1'b0, 5'h0C, oc(4'h0, 2'b11, 1'b1, 1'b0, 1'b1));
      adc1 <= 1'b1;
      rdchk(5'h10, 32'h0000_0002);
      adc0 <= 1'b1;
      wait_for(1'b1);
      chk(k, 1);
      @(posedge clk);
      bus(1'b0, 5'h00, sc(4'h0, 2'b01, 1'b0, 1'b1));
      stop_n <= 1'b0;
      wait_for(1'b0);
      @(negedge clk);
      chk({oe, out}, {6'h07, pin_q});
      $display("test over-voltage done");
      print_verdict;
   end
endmodule // mpfp_bench
`default_nettype wire

// >>> verification/mpfp_gate_model.sv
// Far-side model: PWM carrier counter, period and normal phase drive
`timescale 1ns/1ps
`default_nettype none
module mpfp_gate_model #(
   parameter logic [15:0] PRD = 16'h0028
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   output var  logic [15:0] cnt,
   output wire logic [15:0] prd,
   output wire logic [5:0]  pwm_in
);
   // Short sawtooth so the release points come round often
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) cnt <= 16'h0000;
      else cnt <= (cnt == PRD) ? 16'h0000 : cnt + 16'h0001;
   end
   assign prd    = PRD;
   assign pwm_in = (cnt < PRD / 2) ? 6'h07 : 6'h38;
endmodule // mpfp_gate_model
`default_nettype wire
